// *** hdl/gal_consts.vh ***
// Constants for the two-level gas alarm logic.
`ifndef GAL_CONSTS_VH
`define GAL_CONSTS_VH

// Clock rate and timing figures.
`define GAL_SEC_CYCLES 25'h17d7840
`define GAL_FLASH_CYCLES 25'h0bebc20
`define GAL_DELAY_S_RST 8'h02

// Factory-preset values, loaded at manufacture.
`define GAL_SETPOINT1 16'h0032
`define GAL_SETPOINT2 16'h0064
`define GAL_SUPPRESS 16'h0009

// Register addresses.
`define GAL_ADDR_CTRL 4'h0
`define GAL_ADDR_DELAY 4'h1
`define GAL_ADDR_STATUS 4'h2
`define GAL_ADDR_INT_STAT 4'h3
`define GAL_ADDR_INT_MASK 4'h4
`define GAL_ADDR_CONC 4'h5

// Control register fields and reset value.
`define GAL_CTRL_DELAY_EN 0
`define GAL_CTRL_LATCH 1
`define GAL_CTRL_ENERGIZED 2
`define GAL_CTRL_ZERO_FOLLOW 3
`define GAL_CTRL_SENS_CORR 4
`define GAL_CTRL_RST 5'h01

// Interrupt bit positions.
`define GAL_INT_ALARM1 0
`define GAL_INT_ALARM2 1
`define GAL_INT_OVER 2
`define GAL_INT_RESET 3

`endif

// *** hdl/gal_level.v ***
// One alarm level: delay qualification, latch and lamp state.
`default_nettype none

module gal_level (
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // Conditions
    input wire at_or_above,
    input wire sec_tick,
    input wire flash_phase,
    input wire delay_en,
    input wire [7:0] delay_s,
    input wire latch_mode,
    input wire reset_pulse,
    // Results
    output reg alarm,
    output reg contact,
    output reg lamp
);

    reg [7:0] cnt;
    reg latched;
    reg acked;
    wire qualified;

    // The delay restarts from zero on every drop, so a spiky reading never accumulates.
    assign qualified = at_or_above && (!delay_en || delay_s == 8'h00 || cnt >= delay_s);

    always @(posedge core_clk) begin
        if (!rst_n) begin
            cnt <= 8'h00;
            alarm <= 1'b0;
            latched <= 1'b0;
            acked <= 1'b0;
            contact <= 1'b0;
            lamp <= 1'b0;
        end else begin
            if (!at_or_above) begin
                cnt <= 8'h00;
            end else if (sec_tick && cnt < delay_s) begin
                cnt <= cnt + 8'h01;
            end
            alarm <= qualified;
            if (qualified) begin
                latched <= 1'b1;
            end else if (reset_pulse) begin
                latched <= 1'b0;
            end
            if (!qualified) begin
                acked <= 1'b0;
            end else if (reset_pulse) begin
                acked <= 1'b1;
            end
            if (latch_mode) begin
                contact <= qualified || latched;
                if (!qualified) begin
                    lamp <= 1'b0;
                end else if (acked || reset_pulse) begin
                    lamp <= 1'b1;
                end else begin
                    lamp <= flash_phase;
                end
            end else begin
                contact <= qualified;
                lamp <= qualified;
            end
        end
    end

endmodule

`default_nettype wire

// *** hdl/gal_top.v ***
// Top of the two-level gas alarm logic with its register port.
`default_nettype none
`include "gal_consts.vh"

// Summary of operation
// - Alarm when measured concentration is at or above the setpoint.
// - Two independent levels, each lamp lit at its own setpoint.
// - Alarm delay, two seconds by default, may be switched off.
// - Both setpoints are fixed factory constants.
// - Auto-reset mode: contact closes once concentration reaches the setpoint.
// - Auto-reset mode: contact releases alone when concentration falls below.
// - Self-latching mode: contact also closes at the setpoint.
// - Self-latching mode: lamp flashes while alarmed and not yet reset.
// - Self-latching mode: flashing lamp turns steady after a reset.
// - Self-latching mode: lamp goes out when concentration falls below.
// - In detection mode, mode, up, down or set key resets alarms.
// - Over-range concentration shows a fixed over-scale symbol.
// - Green power lamp stays lit steadily while operating.
// - Setting display cycles setpoints, delay, suppression, zero-follow, correction, wraps.
// - Zero-follow item is skipped unless a compatible sensor unit is fitted.
// - Energized contact mode: contact reads activated when the detector is off.
module gal_top #(
    parameter [24:0] SEC_CYCLES = `GAL_SEC_CYCLES,
    parameter [24:0] FLASH_CYCLES = `GAL_FLASH_CYCLES
) (
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // Measurement from the sensing path
    input wire [15:0] conc,
    input wire over_range,
    input wire detection_mode,
    input wire setting_active,
    input wire sensor_unit_type_a,
    input wire sensor_unit_type_b,
    input wire detector_on,
    // Front keys, asynchronous pins
    input wire key_mode,
    input wire key_up,
    input wire key_down,
    input wire key_set,
    // Register port
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    output wire irq,
    // Lamps and contacts
    output wire first_alarm_lamp,
    output wire second_alarm_lamp,
    output reg power_lamp,
    output reg contact1_coil,
    output reg contact2_coil,
    // Display
    output reg disp_over_scale,
    output reg [5:0] disp_item,
    output reg [15:0] disp_value
);

    // Setting display items, one-hot.
    localparam [5:0] ST_SP1 = 6'h01;
    localparam [5:0] ST_SP2 = 6'h02;
    localparam [5:0] ST_DLY = 6'h04;
    localparam [5:0] ST_SUP = 6'h08;
    localparam [5:0] ST_ZF = 6'h10;
    localparam [5:0] ST_SC = 6'h20;

    reg [4:0] ctrl;
    reg [7:0] delay_s;
    reg [3:0] int_stat;
    reg [3:0] int_mask;
    reg [5:0] item;
    reg [5:0] next_item;
    reg [24:0] sec_cnt;
    reg [24:0] flash_cnt;
    reg sec_tick;
    reg flash_phase;
    reg setting_q;
    reg over_q;
    reg [1:0] alarm_q;
    reg [3:0] key_s1;
    reg [3:0] key_s2;
    reg [3:0] key_s3;
    reg [3:0] key_stable;
    reg [3:0] key_prev;
    wire [3:0] key_pin;
    wire [3:0] key_press;
    wire reset_pulse;
    wire zf_fitted;
    wire step_fwd;
    wire step_back;
    wire [1:0] at_or_above;
    wire [1:0] alarm;
    wire [1:0] contact;
    wire [3:0] events;
    wire rd_int;
    wire [31:0] status_word;
    wire [1:0] lamp;

    assign key_pin = {key_set, key_down, key_up, key_mode};

    // Three-stage key synchroniser; a level is taken once stages two and three agree.
    genvar k;
    generate
        for (k = 0; k < 4; k = k + 1) begin : g_key
            always @(posedge core_clk) begin
                if (!rst_n) begin
                    key_s1[k] <= 1'b0;
                    key_s2[k] <= 1'b0;
                    key_s3[k] <= 1'b0;
                    key_stable[k] <= 1'b0;
                    key_prev[k] <= 1'b0;
                end else begin
                    key_s1[k] <= key_pin[k];
                    key_s2[k] <= key_s1[k];
                    key_s3[k] <= key_s2[k];
                    if (key_s2[k] == key_s3[k]) begin
                        key_stable[k] <= key_s3[k];
                    end
                    key_prev[k] <= key_stable[k];
                end
            end
        end
    endgenerate

    assign key_press = key_stable & ~key_prev;
    assign reset_pulse = detection_mode && (key_press != 4'h0);

    // Setpoints are compile-time constants, never written by software.
    assign at_or_above[0] = (conc >= `GAL_SETPOINT1) || over_range;
    assign at_or_above[1] = (conc >= `GAL_SETPOINT2) || over_range;

    // One-second tick for the delay count.
    always @(posedge core_clk) begin
        if (!rst_n) begin
            sec_cnt <= 25'h0000000;
            sec_tick <= 1'b0;
        end else begin
            sec_tick <= (sec_cnt == SEC_CYCLES - 25'h0000001);
            if (sec_cnt == SEC_CYCLES - 25'h0000001) begin
                sec_cnt <= 25'h0000000;
            end else begin
                sec_cnt <= sec_cnt + 25'h0000001;
            end
        end
    end

    // One flash phase serves both lamps, so two latched levels blink in step.
    always @(posedge core_clk) begin
        if (!rst_n) begin
            flash_cnt <= 25'h0000000;
            flash_phase <= 1'b0;
        end else if (flash_cnt == FLASH_CYCLES - 25'h0000001) begin
            flash_cnt <= 25'h0000000;
            flash_phase <= ~flash_phase;
        end else begin
            flash_cnt <= flash_cnt + 25'h0000001;
        end
    end

    // The tick runs free, so a delay of N seconds may end up to one tick early.
    genvar l;
    generate
        for (l = 0; l < 2; l = l + 1) begin : g_level
            gal_level gal_level_i (
                .core_clk(core_clk),
                .rst_n(rst_n),
                .at_or_above(at_or_above[l]),
                .sec_tick(sec_tick),
                .flash_phase(flash_phase),
                .delay_en(ctrl[`GAL_CTRL_DELAY_EN]),
                .delay_s(delay_s),
                .latch_mode(ctrl[`GAL_CTRL_LATCH]),
                .reset_pulse(reset_pulse),
                .alarm(alarm[l]),
                .contact(contact[l]),
                .lamp(lamp[l])
            );
        end
    endgenerate

    assign first_alarm_lamp = lamp[0];
    assign second_alarm_lamp = lamp[1];

    // Power lamp follows the power switch steadily; it is never blinked.
    always @(posedge core_clk) begin
        if (!rst_n) begin
            power_lamp <= 1'b0;
        end else begin
            power_lamp <= detector_on;
        end
    end

    // Coil drive: in energized mode the relay is held in the quiet state, so loss of
    // power drops it into the activated position.
    always @(posedge core_clk) begin
        if (!rst_n) begin
            contact1_coil <= 1'b0;
            contact2_coil <= 1'b0;
        end else begin
            if (!detector_on) begin
                contact1_coil <= 1'b0;
                contact2_coil <= 1'b0;
            end else if (ctrl[`GAL_CTRL_ENERGIZED]) begin
                contact1_coil <= ~contact[0];
                contact2_coil <= ~contact[1];
            end else begin
                contact1_coil <= contact[0];
                contact2_coil <= contact[1];
            end
        end
    end

    // Setting display sequencer.
    assign zf_fitted = sensor_unit_type_a || sensor_unit_type_b;
    assign step_fwd = setting_active && (key_press[1] || key_press[3]);
    assign step_back = setting_active && key_press[2];

    always @* begin
        next_item = item;
        if (setting_active && !setting_q) begin
            next_item = ST_SP1;
        end else if (step_fwd) begin
            case (item)
                ST_SP1: next_item = ST_SP2;
                ST_SP2: next_item = ST_DLY;
                ST_DLY: next_item = ST_SUP;
                ST_SUP: next_item = zf_fitted ? ST_ZF : ST_SC;
                ST_ZF: next_item = ST_SC;
                ST_SC: next_item = ST_SP1;
                default: next_item = ST_SP1;
            endcase
        end else if (step_back) begin
            case (item)
                ST_SP1: next_item = ST_SC;
                ST_SP2: next_item = ST_SP1;
                ST_DLY: next_item = ST_SP2;
                ST_SUP: next_item = ST_DLY;
                ST_ZF: next_item = ST_SUP;
                ST_SC: next_item = zf_fitted ? ST_ZF : ST_SUP;
                default: next_item = ST_SP1;
            endcase
        end
    end

    // Entering the setting display always starts from the first setpoint.
    always @(posedge core_clk) begin
        if (!rst_n) begin
            item <= ST_SP1;
            setting_q <= 1'b0;
        end else begin
            item <= next_item;
            setting_q <= setting_active;
        end
    end

    always @(posedge core_clk) begin
        if (!rst_n) begin
            disp_item <= 6'h00;
            disp_value <= 16'h0000;
            disp_over_scale <= 1'b0;
        end else begin
            disp_over_scale <= over_range && !setting_active;
            if (setting_active) begin
                disp_item <= next_item;
                case (next_item)
                    ST_SP1: disp_value <= `GAL_SETPOINT1;
                    ST_SP2: disp_value <= `GAL_SETPOINT2;
                    ST_DLY: disp_value <= {8'h00, delay_s};
                    ST_SUP: disp_value <= `GAL_SUPPRESS;
                    ST_ZF: disp_value <= {15'h0000, ctrl[`GAL_CTRL_ZERO_FOLLOW]};
                    ST_SC: disp_value <= {15'h0000, ctrl[`GAL_CTRL_SENS_CORR]};
                    default: disp_value <= 16'h0000;
                endcase
            end else begin
                disp_item <= 6'h00;
                disp_value <= over_range ? 16'hffff : conc;
            end
        end
    end

    // Event edge detectors; they idle low like their sources, so reset makes no false event.
    always @(posedge core_clk) begin
        if (!rst_n) begin
            over_q <= 1'b0;
            alarm_q <= 2'b00;
        end else begin
            over_q <= over_range;
            alarm_q <= alarm;
        end
    end

    assign events = {reset_pulse, over_range && !over_q, alarm & ~alarm_q};
    assign rd_int = reg_rd && (reg_addr == `GAL_ADDR_INT_STAT);
    assign irq = (int_stat & int_mask) != 4'h0;
    assign status_word = {26'h0000000, setting_active, over_range, contact, alarm};

    // Sticky status; an event in the cycle of the clearing read is kept, so none is lost.
    always @(posedge core_clk) begin
        if (!rst_n) begin
            int_stat <= 4'h0;
        end else begin
            int_stat <= (rd_int ? 4'h0 : int_stat) | events;
        end
    end

    // Writable registers; writes to read-only or unmapped offsets are ignored.
    always @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl <= `GAL_CTRL_RST;
            delay_s <= `GAL_DELAY_S_RST;
            int_mask <= 4'h0;
        end else if (reg_wr) begin
            case (reg_addr)
                `GAL_ADDR_CTRL: ctrl <= reg_wdata[4:0];
                `GAL_ADDR_DELAY: delay_s <= reg_wdata[7:0];
                `GAL_ADDR_INT_MASK: int_mask <= reg_wdata[3:0];
                default: ctrl <= ctrl;
            endcase
        end
    end

    // Read data stand only in the cycle after the strobe, then fall back to zero.
    always @(posedge core_clk) begin
        if (!rst_n) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                `GAL_ADDR_CTRL: reg_rdata <= {27'h0000000, ctrl};
                `GAL_ADDR_DELAY: reg_rdata <= {24'h000000, delay_s};
                `GAL_ADDR_STATUS: reg_rdata <= status_word;
                `GAL_ADDR_INT_STAT: reg_rdata <= {28'h0000000, int_stat};
                `GAL_ADDR_INT_MASK: reg_rdata <= {28'h0000000, int_mask};
                `GAL_ADDR_CONC: reg_rdata <= {16'h0000, conc};
                default: reg_rdata <= 32'h00000000;
            endcase
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

endmodule

`default_nettype wire

// *** dv/gal_top_checker.sv ***
// Port assertions for the two-level gas alarm logic.
`default_nettype none
`include "gal_consts.vh"
module gal_top_checker (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Inputs watched
    input wire logic [15:0] conc,
    input wire logic over_range,
    input wire logic setting_active,
    input wire logic detector_on,
    input wire logic reg_rd,
    // Outputs watched
    input wire logic [31:0] reg_rdata,
    input wire logic irq,
    input wire logic first_alarm_lamp,
    input wire logic second_alarm_lamp,
    input wire logic power_lamp,
    input wire logic contact1_coil,
    input wire logic contact2_coil,
    input wire logic disp_over_scale,
    input wire logic [5:0] disp_item,
    input wire logic [15:0] disp_value
);
    timeunit 1ns;
    timeprecision 1ns;
    wire logic above1 = (conc >= `GAL_SETPOINT1) || over_range;
    wire logic above2 = (conc >= `GAL_SETPOINT2) || over_range;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Read data must not linger, or software would see stale words.
    property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");
    property p_lamp1_rise; $rose(first_alarm_lamp) |-> $past(above1); endproperty
    a_lamp1_rise: assert property (p_lamp1_rise) else $error("lamp one lit below setpoint");
    property p_lamp2_rise; $rose(second_alarm_lamp) |-> $past(above2); endproperty
    a_lamp2_rise: assert property (p_lamp2_rise) else $error("lamp two lit below setpoint");
    property p_lamp1_off; (!above1) [*3] |-> !first_alarm_lamp; endproperty
    a_lamp1_off: assert property (p_lamp1_off) else $error("lamp one stays on");
    property p_lamp2_off; (!above2) [*3] |-> !second_alarm_lamp; endproperty
    a_lamp2_off: assert property (p_lamp2_off) else $error("lamp two stays on");
    property p_off_coils; !$past(detector_on) |-> !contact1_coil && !contact2_coil; endproperty
    a_off_coils: assert property (p_off_coils) else $error("coil driven while off");
    property p_power; $past(rst_n) |-> power_lamp == $past(detector_on); endproperty
    a_power: assert property (p_power) else $error("power lamp not steady");
    property p_over;
        $past(rst_n) && $past(over_range && !setting_active) |-> disp_over_scale && disp_value == 16'hffff;
    endproperty
    a_over: assert property (p_over) else $error("over-scale symbol missing");
    property p_item_onehot; $onehot0(disp_item); endproperty
    a_item_onehot: assert property (p_item_onehot) else $error("item not one-hot");
    property p_item_idle; !$past(setting_active) |-> disp_item == 6'h00; endproperty
    a_item_idle: assert property (p_item_idle) else $error("item shown outside setting");
    c_alarm1: cover property ($rose(first_alarm_lamp));
    c_alarm2: cover property ($rose(second_alarm_lamp));
    c_irq: cover property ($rose(irq));
endmodule
bind gal_top gal_top_checker gal_top_checker_i (.core_clk(core_clk), .rst_n(rst_n), .conc(conc),
    .over_range(over_range), .setting_active(setting_active), .detector_on(detector_on), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .first_alarm_lamp(first_alarm_lamp), .second_alarm_lamp(second_alarm_lamp),
    .power_lamp(power_lamp), .contact1_coil(contact1_coil), .contact2_coil(contact2_coil),
    .disp_over_scale(disp_over_scale), .disp_item(disp_item), .disp_value(disp_value));
`default_nettype wire

// *** dv/gal_central.sv ***
// Model of the central alarm system that reads the two contacts.
`default_nettype none
module gal_central (
    // Coils from the detector
    input wire logic coil1,
    input wire logic coil2,
    // High when the contacts are wired in energized mode
    input wire logic energized,
    // Contact state as the central system sees it
    output logic seen1,
    output logic seen2
);
    timeunit 1ns;
    timeprecision 1ns;
    // An energized contact reads active with its coil dropped, so a power loss alarms too.
    assign seen1 = coil1 ^ energized;
    assign seen2 = coil2 ^ energized;
endmodule
`default_nettype wire

// *** dv/gal_top_tb.sv ***
// Self-checking testbench for the two-level gas alarm logic.
`default_nettype none
`include "gal_consts.vh"
module gal_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] conc = 16'h0;
    logic over_range = 1'b0, detection_mode = 1'b1, setting_active = 1'b0, detector_on = 1'b1;
    logic sensor_unit_type_a = 1'b0, sensor_unit_type_b = 1'b0, energized = 1'b0, prev;
    logic [3:0] keys = 4'h0, reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, d;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    wire [31:0] reg_rdata;
    wire irq, lamp1, lamp2, power_lamp, coil1, coil2, seen1, seen2, over_sc;
    wire [5:0] disp_item;
    wire [15:0] disp_value;
    int failures = 0, samples_checked = 0, cyc = 0, n, k, i;
    always #20 core_clk = ~core_clk;
    gal_top #(.SEC_CYCLES(25'h000000a), .FLASH_CYCLES(25'h0000004)) gal_top_i (.core_clk(core_clk), .rst_n(rst_n),
        .conc(conc), .over_range(over_range), .detection_mode(detection_mode), .setting_active(setting_active),
        .sensor_unit_type_a(sensor_unit_type_a), .sensor_unit_type_b(sensor_unit_type_b),
        .detector_on(detector_on), .key_mode(keys[0]), .key_up(keys[1]), .key_down(keys[2]), .key_set(keys[3]),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq(irq), .first_alarm_lamp(lamp1), .second_alarm_lamp(lamp2), .power_lamp(power_lamp),
        .contact1_coil(coil1), .contact2_coil(coil2), .disp_over_scale(over_sc), .disp_item(disp_item),
        .disp_value(disp_value));
    gal_central gal_central_i (.coil1(coil1), .coil2(coil2), .energized(energized), .seen1(seen1), .seen2(seen2));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task tick(input int c);
        repeat (c) @(posedge core_clk);
        #1;
    endtask
    task wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task rchk(input logic [3:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask
    task setc(input logic [15:0] v);
        @(posedge core_clk);
        conc <= v;
    endtask
    // Keys pass a three-flop synchroniser, so each level is held well past it.
    task press(input int kk);
        @(posedge core_clk);
        keys[kk] <= 1'b1;
        repeat (6) @(posedge core_clk);
        keys[kk] <= 1'b0;
        tick(6);
    endtask
    function automatic logic [31:0] val(input int x);
        case (x)
            0: val = `GAL_SETPOINT1;
            1: val = `GAL_SETPOINT2;
            2: val = 32'h5;
            3: val = `GAL_SUPPRESS;
            default: val = 32'h1;
        endcase
    endfunction
    task done_t(input string s);
        $display("Test %s finished", s);
    endtask
    task wrap_up();
        $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            wrap_up();
        end
    end
    initial begin
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        rchk(`GAL_ADDR_CTRL, 32'h1);
        rchk(`GAL_ADDR_DELAY, 32'h2);
        rchk(`GAL_ADDR_INT_MASK, 32'h0);
        rchk(4'hf, 32'h0);
        chk(power_lamp, 1'b1);
        done_t("reset");
        setc(`GAL_SETPOINT1);
        tick(8);
        setc(`GAL_SETPOINT1 - 16'h1);
        setc(`GAL_SETPOINT1);
        tick(9);
        chk(lamp1, 1'b0);
        for (n = 0; n < 30 && lamp1 !== 1'b1; n++) tick(1);
        chk(lamp1, 1'b1);
        chk(lamp2, 1'b0);
        tick(2);
        chk(seen1, 1'b1);
        setc(`GAL_SETPOINT1 - 16'h1);
        tick(4);
        chk(seen1, 1'b0);
        done_t("delay");
        wr(`GAL_ADDR_CTRL, 32'h0);
        rchk(`GAL_ADDR_INT_STAT, 32'h1);
        setc(`GAL_SETPOINT2);
        tick(5);
        chk(seen2, 1'b1);
        chk(irq, 1'b0);
        rchk(`GAL_ADDR_STATUS, 32'hf);
        rchk(`GAL_ADDR_CONC, `GAL_SETPOINT2);
        wr(`GAL_ADDR_INT_MASK, 32'h3);
        #1;
        chk(irq, 1'b1);
        rchk(`GAL_ADDR_INT_STAT, 32'h3);
        chk(irq, 1'b0);
        setc(16'h0);
        done_t("levels");
        wr(`GAL_ADDR_CTRL, 32'h2);
        setc(`GAL_SETPOINT1);
        tick(4);
        n = 0;
        for (k = 0; k < 16; k++) begin
            prev = lamp1;
            tick(1);
            if (lamp1 !== prev) n++;
        end
        chk(n >= 3, 1'b1);
        press(0);
        n = 0;
        repeat (10) begin
            tick(1);
            if (lamp1 !== 1'b1) n++;
        end
        chk(n, 0);
        chk(lamp2, 1'b0);
        for (k = 0; k < 4; k++) begin
            setc(`GAL_SETPOINT1);
            tick(4);
            setc(16'h0);
            tick(4);
            chk(lamp1, 1'b0);
            chk(seen1, 1'b1);
            press(k);
            chk(seen1, 1'b0);
        end
        done_t("latch");
        wr(`GAL_ADDR_CTRL, 32'h4);
        energized <= 1'b1;
        over_range <= 1'b1;
        tick(5);
        chk(over_sc, 1'b1);
        chk(disp_value, 16'hffff);
        chk(seen1, 1'b1);
        @(posedge core_clk);
        over_range <= 1'b0;
        tick(5);
        chk(seen1, 1'b0);
        @(posedge core_clk);
        detector_on <= 1'b0;
        tick(2);
        chk(seen2, 1'b1);
        @(posedge core_clk);
        detector_on <= 1'b1;
        rchk(`GAL_ADDR_INT_STAT, 32'hf);
        done_t("energized");
        wr(`GAL_ADDR_CTRL, 32'h18);
        wr(`GAL_ADDR_DELAY, 32'h5);
        detection_mode <= 1'b0;
        setting_active <= 1'b1;
        tick(3);
        for (i = 0; i < 2; i++) begin
            for (k = 0; k < 6; k++) begin
                if (i == 0 && k == 4) continue;
                chk(disp_item, 32'h1 << k);
                chk(disp_value, val(k));
                press(3);
            end
            @(posedge core_clk);
            sensor_unit_type_a <= 1'b1;
        end
        chk(disp_item, 32'h1);
        press(2);
        chk(disp_item, 32'h20);
        done_t("setting");
        wrap_up();
    end
endmodule
`default_nettype wire
